/* File: design/rofs_relay_select.v */
`timescale 1ns/1ps
`include "rofs_map.vh"

// Function
// - Hold 8-bit function code 0..36, reset 0; relay acts only with expansion board.
// - Code 0 keeps the relay permanently inactive.
// - Code 1 asserts relay when powered up and fault free.
// - Code 2 asserts relay while drive runs.
// - Code 3 asserts relay while running forward.
// - Code 4 asserts relay while running reverse.
// - Code 5 asserts relay during DC injection braking.
// - Code 6 asserts relay inside zero band, stopped included.
// - Code 7 asserts relay inside zero band only while running.
// - Codes 9 and 10 follow first and second threshold comparators.
// - Code 11 asserts relay inside frequency arrival window.
// - Code 12 asserts relay while set frequency exceeds upper limit.
// - Code 13 asserts relay while set frequency is below lower limit.
module rofs_relay_select
#(
   // Bus geometry
   parameter DATA_W = 32,
   parameter ADDR_W = 4,
   // Width of the stored function code
   parameter FUNC_W = `ROFS_FUNC_W
)
(
   // System
   input  wire                  SYS_CLK,
   input  wire                  SYS_RST,
   // Wishbone slave
   input  wire                  WB_CYC_I,
   input  wire                  WB_STB_I,
   input  wire                  WB_WE_I,
   input  wire [ADDR_W-1:0]     WB_ADR_I,
   input  wire [DATA_W/8-1:0]   WB_SEL_I,
   input  wire [DATA_W-1:0]     WB_DAT_I,
   output wire [DATA_W-1:0]     WB_DAT_O,
   output wire                  WB_ACK_O,
   output wire                  WB_ERR_O,
   // Drive status from the motor-control core
   input  wire                  EXP_BOARD_PRESENT,
   input  wire                  POWER_UP_DONE,
   input  wire                  FAULT_ACTIVE,
   input  wire                  DRIVE_RUNNING,
   input  wire                  DIR_REVERSE,
   input  wire                  DC_BRAKING,
   input  wire                  ZERO_BAND,
   input  wire                  FREQ_DETECT_THRESHOLD_ONE,
   input  wire                  FREQ_DETECT_THRESHOLD_TWO,
   input  wire                  FREQUENCY_ARRIVAL,
   input  wire                  ABOVE_UPPER_LIMIT,
   input  wire                  BELOW_LOWER_LIMIT,
   // Relay drive
   output wire                  RELAY_OUTPUT_FOUR
);

   ////////////////////////////////////////////////////////////////////////////////
   // Sized copies of the shared constants, matched to the bus and code widths

   // Register map
   localparam [ADDR_W-1:0] ADR_FUNC = `ROFS_ADDR_FUNC;
   localparam [ADDR_W-1:0] ADR_STAT = `ROFS_ADDR_STATUS;

   // Code limits
   localparam [FUNC_W-1:0] FUNC_RESET = `ROFS_FUNC_RESET;
   localparam [FUNC_W-1:0] FUNC_MAX   = `ROFS_FUNC_MAX;

   // Function codes this block implements; every other code leaves the relay off.
   // Code 8 and codes 14 to 36 are still stored and read back, so software sees
   // what it wrote, but their status sources live outside this block.
   // Limitation: selecting one of them is legal and simply keeps the contact open.
   localparam [FUNC_W-1:0] CODE_UNUSED   = `ROFS_CODE_UNUSED;
   localparam [FUNC_W-1:0] CODE_READY    = `ROFS_CODE_READY;
   localparam [FUNC_W-1:0] CODE_RUN      = `ROFS_CODE_RUN;
   localparam [FUNC_W-1:0] CODE_FWD      = `ROFS_CODE_FWD;
   localparam [FUNC_W-1:0] CODE_REV      = `ROFS_CODE_REV;
   localparam [FUNC_W-1:0] CODE_DCBRK    = `ROFS_CODE_DCBRK;
   localparam [FUNC_W-1:0] CODE_ZERO     = `ROFS_CODE_ZERO;
   localparam [FUNC_W-1:0] CODE_ZERO_RUN = `ROFS_CODE_ZERO_RUN;
   localparam [FUNC_W-1:0] CODE_FREQ_DETECT_THRESHOLD_ONE     = `ROFS_CODE_FREQ_DETECT_THRESHOLD_ONE;
   localparam [FUNC_W-1:0] CODE_FREQ_DETECT_THRESHOLD_TWO     = `ROFS_CODE_FREQ_DETECT_THRESHOLD_TWO;
   localparam [FUNC_W-1:0] CODE_ARRIVE   = `ROFS_CODE_ARRIVE;
   localparam [FUNC_W-1:0] CODE_UPLIM    = `ROFS_CODE_UPLIM;
   localparam [FUNC_W-1:0] CODE_LOLIM    = `ROFS_CODE_LOLIM;

   ////////////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   // True when the address selects the function code register;
   // shared by the answer, read data and write paths
   function addr_is_func
   (
      input [ADDR_W-1:0] adr
   );
      begin
         addr_is_func = (adr == ADR_FUNC);
      end
   endfunction

   // True when the address selects the read-only status word;
   // writes there are acked and dropped
   function addr_is_stat
   (
      input [ADDR_W-1:0] adr
   );
      begin
         addr_is_stat = (adr == ADR_STAT);
      end
   endfunction

   // Codes above the top of the range are refused, so the stored value
   // can never hold something software could not have meant
   function code_in_range
   (
      input [FUNC_W-1:0] code
   );
      begin
         code_in_range = (code <= FUNC_MAX);
      end
   endfunction

   // Picks the status condition named by the code.
   // Forward and reverse only count while the drive runs, so a stopped drive
   // with a stale direction bit never closes the contact.
   // The zero band alone covers the stopped state too; code 7 adds the run
   // qualifier so a standing drive stays silent.
   function pick_condition
   (
      input [FUNC_W-1:0] code,
      input              ready,
      input              running,
      input              reverse,
      input              braking,
      input              zero_band,
      input              thresh_one,
      input              thresh_two,
      input              arrival,
      input              above_upper,
      input              below_lower
   );
      begin
         case (code)
            CODE_UNUSED:
               pick_condition = 1'h0;
            CODE_READY:
               pick_condition = ready;
            CODE_RUN:
               pick_condition = running;
            CODE_FWD:
               pick_condition = running & ~reverse;
            CODE_REV:
               pick_condition = running & reverse;
            CODE_DCBRK:
               pick_condition = braking;
            CODE_ZERO:
               pick_condition = zero_band;
            CODE_ZERO_RUN:
               pick_condition = zero_band & running;
            CODE_FREQ_DETECT_THRESHOLD_ONE:
               pick_condition = thresh_one;
            CODE_FREQ_DETECT_THRESHOLD_TWO:
               pick_condition = thresh_two;
            CODE_ARRIVE:
               pick_condition = arrival;
            CODE_UPLIM:
               pick_condition = above_upper;
            CODE_LOLIM:
               pick_condition = below_lower;
            default:
               pick_condition = 1'h0;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Storage and internal nets

   // Registers
   reg  [FUNC_W-1:0] relay4_function_select_q;
   reg               relay_q;
   reg               ack_q;
   reg               err_q;
   reg  [DATA_W-1:0] rdata_q;

   // Combinational values
   reg               relay_d;
   reg               cond_sel;
   reg  [DATA_W-1:0] status_word;

   // Request qualifiers
   wire              bus_req;
   wire              req_func;
   wire              req_stat;
   wire              req_unmapped;
   wire              func_write_ok;
   wire              ready_now;

   ////////////////////////////////////////////////////////////////////////////////
   // Request qualification

   // A request already answered is not taken again while the master still holds it
   assign bus_req      = WB_CYC_I & WB_STB_I & ~ack_q & ~err_q;
   assign req_func     = bus_req & addr_is_func(WB_ADR_I);
   assign req_stat     = bus_req & addr_is_stat(WB_ADR_I);
   assign req_unmapped = bus_req & ~addr_is_func(WB_ADR_I) & ~addr_is_stat(WB_ADR_I);

   // Only byte lane 0 carries the code; a refused value is acked but leaves the code.
   // Status writes never reach storage: the status word has no flip-flops of its own.
   assign func_write_ok = req_func & WB_WE_I & WB_SEL_I[0] &
                          code_in_range(WB_DAT_I[FUNC_W-1:0]);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus answer: one wait state, ack or err stands for one cycle

   // Ack for the two mapped addresses; it drops on its own the cycle after,
   // because a pending ack masks the still-held request
   always @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         ack_q <= 1'h0;
      end
      else
      begin
         ack_q <= req_func | req_stat;
      end
   end

   // Err for any other address, so a stray access never hangs the master
   // waiting for an ack that would not come
   always @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         err_q <= 1'h0;
      end
      else
      begin
         err_q <= req_unmapped;
      end
   end

   // Read data is zero outside the answer cycle so slaves can be ORed together;
   // the cost is one flip-flop stage on the read path
   always @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         rdata_q <= {DATA_W{1'h0}};
      end
      else if (req_func)
      begin
         rdata_q <= {{(DATA_W-FUNC_W){1'h0}}, relay4_function_select_q};
      end
      else if (req_stat)
      begin
         rdata_q <= status_word;
      end
      else
      begin
         rdata_q <= {DATA_W{1'h0}};
      end
   end

   // Status word: live relay state and board presence, all other bits zero;
   // the relay bit is the registered drive, not the contact itself
   always @*
   begin
      status_word                 = {DATA_W{1'h0}};
      status_word[`ROFS_ST_RELAY] = relay_q;
      status_word[`ROFS_ST_EXP]   = EXP_BOARD_PRESENT;
   end

   // Bus outputs straight from flip-flops
   assign WB_ACK_O = ack_q;
   assign WB_ERR_O = err_q;
   assign WB_DAT_O = rdata_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Function code register

   // Rewritten only by an accepted, in-range write to byte lane 0;
   // the write lands at the edge that takes the request, the same edge that raises the ack
   always @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         relay4_function_select_q <= FUNC_RESET;
      end
      else if (func_write_ok)
      begin
         relay4_function_select_q <= WB_DAT_I[FUNC_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Condition select

   // The status lines are levels from the core, already in this clock domain,
   // so they are used as they stand; the threshold and band comparators that
   // make them are outside this block.

   // Ready means powered up with no fault present
   assign ready_now = POWER_UP_DONE & ~FAULT_ACTIVE;

   // Picks the status line named by the code; relays two to four need the board,
   // so without it the contact stays open whatever the code says
   always @*
   begin
      cond_sel = pick_condition(relay4_function_select_q,
                                ready_now,
                                DRIVE_RUNNING,
                                DIR_REVERSE,
                                DC_BRAKING,
                                ZERO_BAND,
                                FREQ_DETECT_THRESHOLD_ONE,
                                FREQ_DETECT_THRESHOLD_TWO,
                                FREQUENCY_ARRIVAL,
                                ABOVE_UPPER_LIMIT,
                                BELOW_LOWER_LIMIT);
      relay_d  = cond_sel & EXP_BOARD_PRESENT;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Relay output

   // Registered so a code rewrite or a hazard in the select never chatters the coil;
   // the cost is one clock of latency, far below the contact's own delay.
   // Reset opens the contact at once, without waiting for a clock.
   always @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         relay_q <= 1'h0;
      end
      else
      begin
         relay_q <= relay_d;
      end
   end

   // Contact coil drive
   assign RELAY_OUTPUT_FOUR = relay_q;

endmodule

/* File: shared/rofs_map.vh */
`ifndef ROFS_MAP_VH
`define ROFS_MAP_VH
// Register byte addresses (word aligned)
`define ROFS_ADDR_FUNC      4'h0
`define ROFS_ADDR_STATUS    4'h4
// Function select register
`define ROFS_FUNC_W         8
`define ROFS_FUNC_RESET     8'h00
`define ROFS_FUNC_MAX       8'h24
// Function codes
`define ROFS_CODE_UNUSED    8'h00
`define ROFS_CODE_READY     8'h01
`define ROFS_CODE_RUN       8'h02
`define ROFS_CODE_FWD       8'h03
`define ROFS_CODE_REV       8'h04
`define ROFS_CODE_DCBRK     8'h05
`define ROFS_CODE_ZERO      8'h06
`define ROFS_CODE_ZERO_RUN  8'h07
`define ROFS_CODE_FREQ_DETECT_THRESHOLD_ONE      8'h09
`define ROFS_CODE_FREQ_DETECT_THRESHOLD_TWO      8'h0A
`define ROFS_CODE_ARRIVE    8'h0B
`define ROFS_CODE_UPLIM     8'h0C
`define ROFS_CODE_LOLIM     8'h0D
// Status register bit positions
`define ROFS_ST_RELAY       0
`define ROFS_ST_EXP         1
`endif

/* File: testbench/rofs_chk_properties.sv */
`timescale 1ns/1ps
// Bus handshake and relay gating, seen at the block's ports only
module rofs_chk (input wire SYS_CLK, SYS_RST, WB_CYC_I, WB_STB_I, WB_ACK_O, WB_ERR_O,
   EXP_BOARD_PRESENT, RELAY_OUTPUT_FOUR, input wire [31:0] WB_DAT_O);
   wire take = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   // Answer one cycle after the taking edge, gone in the cycle after
   sequence s_ans; ##1 (WB_ACK_O || WB_ERR_O) ##1 !(WB_ACK_O || WB_ERR_O); endsequence
   chk_bus_answer: assert property (take |-> s_ans) else $error("late answer");
   chk_ack_alone: assert property (!(WB_ACK_O && WB_ERR_O)) else $error("ack and err");
   chk_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_STB_I)) else $error("no req");
   chk_bus_quiet: assert property (!WB_CYC_I |=> !WB_ACK_O) else $error("stray ack");
   chk_data_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("stray data");
   chk_data_byte: assert property (WB_DAT_O[31:8] == 24'h0) else $error("upper data");
   chk_board_gate: assert property (!EXP_BOARD_PRESENT |=> !RELAY_OUTPUT_FOUR)
      else $error("relay without board");
   chk_relay_rise: assert property ($rose(RELAY_OUTPUT_FOUR) |-> $past(EXP_BOARD_PRESENT))
      else $error("relay rose alone");
endmodule
bind rofs_relay_select rofs_chk rofs_chk_inst (.*);

/* File: testbench/rofs_contact.sv */
`timescale 1ns/1ps
// Field contact; the armature is slow, so it follows the coil one clock late
module rofs_contact (input wire clk, input wire coil, output reg closed);
   initial closed = 1'b0;
   always @(posedge clk) closed <= coil;
endmodule

/* File: testbench/rofs_relay_select_bench.sv */
`timescale 1ns/1ps
module rofs_relay_select_bench;
   reg         SYS_CLK = 1'b0, SYS_RST = 1'b1, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
   reg  [3:0]  WB_ADR_I = 4'h0, WB_SEL_I = 4'hF;
   reg  [31:0] WB_DAT_I = 32'h0, rd;
   reg  [13:0] v;
   reg  [11:0] s = 12'h000;
   reg  [1:0]  e;
   wire [31:0] WB_DAT_O;
   wire        WB_ACK_O, WB_ERR_O, RELAY_OUTPUT_FOUR, closed;
   integer     err_count = 0, checks_done = 0, i, k;
   always #10 SYS_CLK = ~SYS_CLK;
   rofs_relay_select rofs_relay_select_inst (.*, .EXP_BOARD_PRESENT(s[0]), .POWER_UP_DONE(s[1]),
      .FAULT_ACTIVE(s[2]), .DRIVE_RUNNING(s[3]), .DIR_REVERSE(s[4]), .DC_BRAKING(s[5]),
      .ZERO_BAND(s[6]), .FREQ_DETECT_THRESHOLD_ONE(s[7]), .FREQ_DETECT_THRESHOLD_TWO(s[8]),
      .FREQUENCY_ARRIVAL(s[9]), .ABOVE_UPPER_LIMIT(s[10]), .BELOW_LOWER_LIMIT(s[11]));
   rofs_contact rofs_contact_inst (.clk(SYS_CLK), .coil(RELAY_OUTPUT_FOUR), .closed(closed));
   task check(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp)
         begin
            err_count = err_count + 1;
            $display("FAIL %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   // Holds the request until ack or err is seen; err reads back as a marker
   task wb(input w, input [3:0] a, input [31:0] d);
      begin
         WB_CYC_I <= 1'b1; WB_STB_I <= 1'b1; WB_WE_I <= w; WB_ADR_I <= a; WB_DAT_I <= d;
         @(posedge SYS_CLK);
         while (!(WB_ACK_O || WB_ERR_O)) @(posedge SYS_CLK);
         rd = WB_ERR_O ? 32'hEEEEEEEE : WB_DAT_O;
         WB_CYC_I <= 1'b0; WB_STB_I <= 1'b0;
         @(posedge SYS_CLK);
      end
   endtask
   task t_regs;
      begin
         wb(0, 4'h0, 32'h0); check(rd, 32'h0);
         wb(1, 4'h0, 32'h24); wb(1, 4'h0, 32'h25); wb(0, 4'h0, 32'h0); check(rd, 32'h24);
         WB_SEL_I <= 4'hE; wb(1, 4'h0, 32'h1); WB_SEL_I <= 4'hF;
         wb(0, 4'h0, 32'h0); check(rd, 32'h24);
         wb(0, 4'h8, 32'h0); check(rd, 32'hEEEEEEEE);
         s <= 12'h001; wb(1, 4'h4, 32'h0); wb(0, 4'h4, 32'h0); check(rd, 32'h2);
      end
   endtask
   // Reset in mid-run puts the code back to zero and opens the relay
   task t_reset;
      begin
         wb(1, 4'h0, 32'h1); s <= 12'h003; repeat (3) @(posedge SYS_CLK);
         check(RELAY_OUTPUT_FOUR, 32'h1);
         SYS_RST <= 1'b1; repeat (2) @(posedge SYS_CLK); SYS_RST <= 1'b0;
         check(RELAY_OUTPUT_FOUR, 32'h0);
         @(posedge SYS_CLK); wb(0, 4'h0, 32'h0); check(rd, 32'h0);
      end
   endtask
   // Codes 0 to 15 under stirred status; the contact trails the inputs by two clocks
   task t_codes;
      begin
         for (i = 0; i < 16; i = i + 1)
         begin
            wb(1, 4'h0, i);
            for (k = 0; k < 40; k = k + 1)
            begin
               @(posedge SYS_CLK);
               if (k > 1) check(closed, e[1]);
               v = {s[11:7],1'b0,s[6]&s[3],s[6],s[5],s[3]&s[4],s[3]&!s[4],s[3],s[1]&!s[2],1'b0};
               e = {e[0], s[0] && i < 14 && v[i[3:0]]};
               s <= s * 12'hC35 + 12'h3A7;
            end
         end
      end
   endtask
   initial
   begin
      repeat (8) @(posedge SYS_CLK);
      SYS_RST <= 1'b0;
      @(posedge SYS_CLK);
      t_regs;
      t_codes;
      t_reset;
      give_verdict;
   end
   // The run needs under a thousand clocks; this leaves ample margin
   initial
   begin
      #300000;
      err_count = err_count + 1;
      give_verdict;
   end
   task give_verdict;
      begin
         if (err_count == 0 && checks_done > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
endmodule
